/* core/csbm_pkg.sv */
// Constants shared by the core status register and banked data memory map.
package csbm_pkg;

  // ****************************************************************
  // Address layout
  // ****************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned BANK_W = 5;
  localparam int unsigned OFS_W = 7;
  localparam logic [OFS_W-1:0] OFS_STATUS = 7'h03;
  localparam logic [OFS_W-1:0] OFS_CORE_LAST = 7'h0B;
  localparam logic [OFS_W-1:0] OFS_SFR_FIRST = 7'h0C;
  localparam logic [OFS_W-1:0] OFS_SFR_LAST = 7'h1F;
  localparam logic [OFS_W-1:0] OFS_GPR_FIRST = 7'h20;
  localparam logic [OFS_W-1:0] OFS_GPR_LAST = 7'h6F;
  localparam logic [OFS_W-1:0] OFS_COMMON_FIRST = 7'h70;
  localparam int unsigned GPR_PER_BANK = 80;
  localparam int unsigned COMMON_BYTES = 16;
  localparam int unsigned COMMON_IDX_W = 4;

  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int unsigned DATA_W = 8;
  localparam int unsigned BIT_TIMEOUT = 4;
  localparam int unsigned BIT_POWERDOWN = 3;
  localparam int unsigned BIT_ZERO = 2;
  localparam int unsigned BIT_DIGIT_CARRY = 1;
  localparam int unsigned BIT_CARRY = 0;
  localparam int unsigned NIBBLE_W = 4;
  localparam logic RST_TIMEOUT = 1'b1;
  localparam logic RST_POWERDOWN = 1'b1;
  localparam logic RST_ALU_FLAG = 1'b0;
  localparam logic [2:0] UNIMPL_BITS = 3'h0;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  // ****************************************************************
  // Flag-affecting operations
  // ****************************************************************
  typedef enum logic [2:0] {
    CSBM_OP_NONE,
    CSBM_OP_ADD,
    CSBM_OP_SUB,
    CSBM_OP_LOGIC,
    CSBM_OP_ROT_LEFT,
    CSBM_OP_ROT_RIGHT
  } csbm_op_e;

endpackage

/* core/csbm_core.sv */
// Status register, flag logic and banked data memory of the core.
//
// Function
// - Status bits seven to five are unimplemented and read zero.
// - Timeout flag set by power-up, watchdog clear or sleep; cleared by timeout.
// - Powerdown flag set by power-up or watchdog clear; cleared by sleep.
// - Timeout and powerdown are read-only, one at power-on, event driven otherwise.
// - Zero flag follows whether an add, subtract or logic result is zero; rotates leave it.
// - Add/subtract set digit carry on carry out of the low nibble.
// - Add/subtract set carry on carry out of the top result bit.
// - Subtraction adds the two's complement, so carries mean no borrow.
// - Rotates load carry with the bit shifted out of the source.
// - Zero, digit carry, carry are writable, cleared at power-on, kept otherwise.
// - Special function registers occupy bank offsets 0Ch through 1Fh in every bank.
// - Each bank offers at most eighty bytes of general RAM.
// - Sixteen bytes of common RAM are shared by every bank.
// - General RAM is also reachable as one linear region by the pointers.
// - Core registers occupy the first twelve offsets of every bank.
// - Addresses are twelve bits: five bank bits, seven offset bits.
// - A status write is dropped for all three ALU flags when the instruction updates any of them.
// - Unimplemented locations read as zero.
`timescale 1ns/1ps

module csbm_core
  import csbm_pkg::*;
#(
  parameter int unsigned GPR_BANKS = 2
)
(
  // Clock, reset and enable
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Reset-cause and power-state events
  input wire logic i_watchdog_clear_instr,
  input wire logic i_sleep_instr,
  input wire logic i_watchdog_timeout,
  // ALU flag update
  input wire csbm_pkg::csbm_op_e i_alu_op,
  input wire logic [csbm_pkg::DATA_W-1:0] i_alu_a,
  input wire logic [csbm_pkg::DATA_W-1:0] i_alu_b,
  output logic [csbm_pkg::DATA_W-1:0] o_alu_result,
  // Data memory access
  input wire logic i_mem_rd,
  input wire logic i_mem_wr,
  input wire logic i_lin_access,
  input wire logic [csbm_pkg::ADDR_W-1:0] i_mem_addr,
  input wire logic [csbm_pkg::DATA_W-1:0] i_mem_wr_data,
  output logic [csbm_pkg::DATA_W-1:0] o_mem_rd_data,
  // Core and special function registers held outside this block
  output logic o_ext_sel,
  input wire logic [csbm_pkg::DATA_W-1:0] i_ext_rd_data,
  // Status view
  output logic [csbm_pkg::DATA_W-1:0] o_status
);
  import csbm_pkg::*;

  localparam int unsigned GPR_BYTES = GPR_BANKS * GPR_PER_BANK;
  localparam int unsigned GPR_IDX_W = $clog2(GPR_BYTES);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [GPR_IDX_W-1:0] gpr_index(
    input logic [BANK_W-1:0] bank,
    input logic [OFS_W-1:0] ofs
  );
    logic [ADDR_W-1:0] idx;
    idx = ADDR_W'(bank) * ADDR_W'(GPR_PER_BANK) + ADDR_W'(ofs - OFS_GPR_FIRST);
    return idx[GPR_IDX_W-1:0];
  endfunction

  function automatic logic [DATA_W:0] add_carry(
    input logic [DATA_W-1:0] a,
    input logic [DATA_W-1:0] b,
    input logic cin
  );
    return {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cin};
  endfunction

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic timeout_flag_q;
  logic powerdown_flag_q;
  logic zero_flag_q;
  logic digit_carry_flag_q;
  logic carry_flag_q;
  logic [DATA_W-1:0] general_ram [GPR_BYTES];
  logic [DATA_W-1:0] common_ram [COMMON_BYTES];
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] alu_result_q;

  wire [BANK_W-1:0] bank = i_mem_addr[ADDR_W-1:OFS_W];
  wire [OFS_W-1:0] ofs = i_mem_addr[OFS_W-1:0];
  wire in_core = ofs <= OFS_CORE_LAST;
  wire hit_status = !i_lin_access && ofs == OFS_STATUS;
  wire in_sfr = ofs >= OFS_SFR_FIRST && ofs <= OFS_SFR_LAST;
  wire gpr_ok = int'(bank) < GPR_BANKS;
  wire in_gpr_ofs = ofs >= OFS_GPR_FIRST && ofs <= OFS_GPR_LAST;
  wire hit_gpr_bank = !i_lin_access && in_gpr_ofs && gpr_ok;
  wire hit_common = !i_lin_access && ofs >= OFS_COMMON_FIRST;
  wire hit_gpr_lin = i_lin_access && int'(i_mem_addr) < GPR_BYTES;
  wire hit_ext = !i_lin_access && ((in_core && !hit_status) || in_sfr);
  wire [GPR_IDX_W-1:0] gpr_idx = hit_gpr_lin ? i_mem_addr[GPR_IDX_W-1:0]
                                             : gpr_index(bank, ofs);
  wire [COMMON_IDX_W-1:0] common_idx = ofs[COMMON_IDX_W-1:0];
  wire hit_gpr = hit_gpr_bank || hit_gpr_lin;

  assign o_ext_sel = (i_mem_rd || i_mem_wr) && hit_ext;

  // ****************************************************************
  // Flag computation
  // ****************************************************************
  // Subtraction feeds the inverted operand with a carry-in of one, so the
  // carries come out as not-borrow without any extra inversion.
  wire is_sub = i_alu_op == CSBM_OP_SUB;
  wire [DATA_W-1:0] addend = is_sub ? ~i_alu_b : i_alu_b;
  wire [DATA_W:0] sum_full = add_carry(i_alu_a, addend, is_sub);
  wire [NIBBLE_W:0] sum_low = {1'b0, i_alu_a[NIBBLE_W-1:0]}
                              + {1'b0, addend[NIBBLE_W-1:0]}
                              + {{NIBBLE_W{1'b0}}, is_sub};
  wire arith = i_alu_op == CSBM_OP_ADD || is_sub;
  wire rot_left = i_alu_op == CSBM_OP_ROT_LEFT;
  wire rot_right = i_alu_op == CSBM_OP_ROT_RIGHT;
  wire logic_op = i_alu_op == CSBM_OP_LOGIC;

  logic [DATA_W-1:0] result;
  always_comb
  begin
    case (i_alu_op)
      CSBM_OP_ADD, CSBM_OP_SUB: result = sum_full[DATA_W-1:0];
      CSBM_OP_ROT_LEFT: result = {i_alu_a[DATA_W-2:0], carry_flag_q};
      CSBM_OP_ROT_RIGHT: result = {carry_flag_q, i_alu_a[DATA_W-1:1]};
      default: result = i_alu_a;
    endcase
  end

  wire upd_zero = arith || logic_op;
  wire upd_dc = arith;
  wire upd_carry = arith || rot_left || rot_right;
  wire flags_busy = upd_zero || upd_carry;
  wire status_wr = i_mem_wr && hit_status;
  wire status_wr_alu = status_wr && !flags_busy;

  wire zero_d = upd_zero ? (result == ZERO_BYTE)
              : status_wr_alu ? i_mem_wr_data[BIT_ZERO] : zero_flag_q;
  wire dc_d = upd_dc ? sum_low[NIBBLE_W]
            : status_wr_alu ? i_mem_wr_data[BIT_DIGIT_CARRY] : digit_carry_flag_q;
  wire carry_d = arith ? sum_full[DATA_W]
               : rot_left ? i_alu_a[DATA_W-1]
               : rot_right ? i_alu_a[0]
               : status_wr_alu ? i_mem_wr_data[BIT_CARRY] : carry_flag_q;

  // Setting events win over the timeout that would clear the flag.
  wire timeout_d = (i_watchdog_clear_instr || i_sleep_instr) ? 1'b1
                 : i_watchdog_timeout ? 1'b0 : timeout_flag_q;
  wire powerdown_d = i_watchdog_clear_instr ? 1'b1
                   : i_sleep_instr ? 1'b0 : powerdown_flag_q;

  wire [DATA_W-1:0] status_now = {UNIMPL_BITS, timeout_flag_q, powerdown_flag_q,
                                  zero_flag_q, digit_carry_flag_q, carry_flag_q};
  // A read in the same cycle as a flag update sees the updated flags.
  wire [DATA_W-1:0] status_next = {UNIMPL_BITS, timeout_d, powerdown_d,
                                   zero_d, dc_d, carry_d};

  wire [DATA_W-1:0] rd_mux = hit_status ? status_next
                           : hit_common ? common_ram[common_idx]
                           : hit_gpr ? general_ram[gpr_idx]
                           : hit_ext ? i_ext_rd_data
                           : ZERO_BYTE;

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // The asynchronous reset stands for power-on and brown-out only; other
  // resets are not seen here, so the flags keep their values through them.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      timeout_flag_q <= RST_TIMEOUT;
      powerdown_flag_q <= RST_POWERDOWN;
      zero_flag_q <= RST_ALU_FLAG;
      digit_carry_flag_q <= RST_ALU_FLAG;
      carry_flag_q <= RST_ALU_FLAG;
    end
    else if (i_ce)
    begin
      timeout_flag_q <= timeout_d;
      powerdown_flag_q <= powerdown_d;
      zero_flag_q <= zero_d;
      digit_carry_flag_q <= dc_d;
      carry_flag_q <= carry_d;
    end
  end

  // ****************************************************************
  // Read data and ALU result
  // ****************************************************************
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rd_data_q <= ZERO_BYTE;
      alu_result_q <= ZERO_BYTE;
    end
    else if (i_ce)
    begin
      if (i_mem_rd)
      begin
        rd_data_q <= rd_mux;
      end
      if (i_alu_op != CSBM_OP_NONE)
      begin
        alu_result_q <= result;
      end
    end
  end

  // ****************************************************************
  // RAM storage
  // ****************************************************************
  // RAM contents are not reset, matching real SRAM and keeping the arrays
  // mappable to memory macros.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_ce && i_mem_wr)
    begin
      if (hit_gpr)
      begin
        general_ram[gpr_idx] <= i_mem_wr_data;
      end
      if (hit_common)
      begin
        common_ram[common_idx] <= i_mem_wr_data;
      end
    end
  end

  assign o_mem_rd_data = rd_data_q;
  assign o_alu_result = alu_result_q;
  assign o_status = status_now;

endmodule

/* testbench/csbm_core_asserts.sv */
// Checker of status flag and map behaviour at the core ports.
`timescale 1ns/1ps
module csbm_core_asserts
  import csbm_pkg::*;
(
  // Watched ports
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_watchdog_clear_instr,
  input wire logic i_sleep_instr,
  input wire logic i_watchdog_timeout,
  input wire csbm_pkg::csbm_op_e i_alu_op,
  input wire logic [csbm_pkg::DATA_W-1:0] i_alu_a,
  input wire logic [csbm_pkg::DATA_W-1:0] i_alu_b,
  input wire logic [csbm_pkg::DATA_W-1:0] o_alu_result,
  input wire logic i_mem_rd,
  input wire logic i_mem_wr,
  input wire logic i_lin_access,
  input wire logic [csbm_pkg::ADDR_W-1:0] i_mem_addr,
  input wire logic [csbm_pkg::DATA_W-1:0] i_mem_wr_data,
  input wire logic o_ext_sel,
  input wire logic [csbm_pkg::DATA_W-1:0] o_status
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  wire logic ev_any = i_watchdog_clear_instr || i_sleep_instr || i_watchdog_timeout;
  a_upper_zero: assert property (o_status[7:5] == 3'h0)
    else $error("status upper bits set");
  a_timeout_set: assert property (i_ce && (i_watchdog_clear_instr || i_sleep_instr)
    |=> o_status[4]) else $error("timeout flag not set");
  a_timeout_clear: assert property (i_ce && i_watchdog_timeout
    && !i_watchdog_clear_instr && !i_sleep_instr |=> !o_status[4])
    else $error("timeout flag not cleared");
  a_powerdown_set: assert property (i_ce && i_watchdog_clear_instr |=> o_status[3])
    else $error("powerdown flag not set");
  a_powerdown_clear: assert property (i_ce && i_sleep_instr && !i_watchdog_clear_instr
    |=> !o_status[3]) else $error("powerdown flag not cleared");
  a_reset_flags_hold: assert property (i_ce && !ev_any |=> $stable(o_status[4:3]))
    else $error("reset flags changed without event");
  a_add_carry: assert property (i_ce && i_alu_op == CSBM_OP_ADD
    |=> {o_status[0], o_alu_result} == {1'b0, $past(i_alu_a)} + {1'b0, $past(i_alu_b)})
    else $error("add carry wrong");
  a_digit_carry: assert property (i_ce && i_alu_op == CSBM_OP_ADD
    |=> o_status[1] == ({1'b0, $past(i_alu_a[3:0])} + {1'b0, $past(i_alu_b[3:0])} > 5'h0F))
    else $error("digit carry wrong");
  a_sub_borrow: assert property (i_ce && i_alu_op == CSBM_OP_SUB
    |=> o_status[0] == ($past(i_alu_a) >= $past(i_alu_b))) else $error("sub carry wrong");
  a_zero_result: assert property (i_ce
    && i_alu_op inside {CSBM_OP_ADD, CSBM_OP_SUB, CSBM_OP_LOGIC}
    |=> o_status[2] == (o_alu_result == 8'h00)) else $error("zero flag wrong");
  a_rot_carry: assert property (i_ce && i_alu_op == CSBM_OP_ROT_LEFT
    |=> o_status[0] == $past(i_alu_a[7])) else $error("rotate carry wrong");
  a_rot_right_carry: assert property (i_ce && i_alu_op == CSBM_OP_ROT_RIGHT
    |=> o_status[0] == $past(i_alu_a[0])) else $error("rotate right carry wrong");
  a_status_write: assert property (i_ce && i_mem_wr && !i_lin_access
    && i_mem_addr[6:0] == 7'h03 && i_alu_op == CSBM_OP_NONE
    |=> o_status[2:0] == $past(i_mem_wr_data[2:0])) else $error("status write lost");
  a_write_suppress: assert property (i_ce && i_mem_wr && !i_lin_access
    && i_mem_addr[6:0] == 7'h03 && i_alu_op == CSBM_OP_LOGIC
    |=> o_status[1:0] == $past(o_status[1:0])) else $error("status write not suppressed");
  a_ext_select: assert property (i_ce && (i_mem_rd || i_mem_wr) && !i_lin_access
    |-> o_ext_sel == (i_mem_addr[6:0] <= 7'h1F && i_mem_addr[6:0] != 7'h03))
    else $error("ext select wrong");
endmodule
bind csbm_core csbm_core_asserts u_chk (.i_clk_sys, .i_rst_n, .i_ce, .i_watchdog_clear_instr,
  .i_sleep_instr, .i_watchdog_timeout, .i_alu_op, .i_alu_a, .i_alu_b, .o_alu_result, .i_mem_rd,
  .i_mem_wr, .i_lin_access, .i_mem_addr, .i_mem_wr_data, .o_ext_sel, .o_status);

/* testbench/csbm_ext_model.sv */
// Model of the outside logic that serves core and peripheral registers.
`timescale 1ns/1ps
module csbm_ext_model
(
  // Clock, select and location
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_sel,
  input wire logic [6:0] i_ofs,
  output logic [7:0] o_data
);
  logic [7:0] idle_q;
  // Unselected, the bus changes every cycle so a stale sample cannot pass.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      idle_q <= 8'h5A;
    else
      idle_q <= ~idle_q + 8'h01;
  end
  assign o_data = i_sel ? (8'hC0 ^ {1'b0, i_ofs}) : idle_q;
endmodule

/* testbench/csbm_core_bench.sv */
// Self-checking bench of the status register and banked memory map.
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("[ERR] %s exp %h got %h", n, e, g); \
    end \
  end
module csbm_core_bench;
  import csbm_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_ce = 1'b1;
  logic i_watchdog_clear_instr = 1'b0;
  logic i_sleep_instr = 1'b0;
  logic i_watchdog_timeout = 1'b0;
  csbm_op_e i_alu_op = CSBM_OP_NONE;
  logic [7:0] i_alu_a = 8'h00;
  logic [7:0] i_alu_b = 8'h00;
  logic i_mem_rd = 1'b0;
  logic i_mem_wr = 1'b0;
  logic i_lin_access = 1'b0;
  logic [11:0] i_mem_addr = 12'h000;
  logic [7:0] i_mem_wr_data = 8'h00;
  logic [7:0] i_ext_rd_data, o_alu_result, o_mem_rd_data, o_status;
  logic o_ext_sel;
  int fails = 0;
  int checks = 0;
  always #10 i_clk_sys = ~i_clk_sys;
  csbm_core #(.GPR_BANKS(2)) dut (.i_clk_sys, .i_rst_n, .i_ce, .i_watchdog_clear_instr,
    .i_sleep_instr, .i_watchdog_timeout, .i_alu_op, .i_alu_a, .i_alu_b, .o_alu_result,
    .i_mem_rd, .i_mem_wr, .i_lin_access, .i_mem_addr, .i_mem_wr_data, .o_mem_rd_data,
    .o_ext_sel, .i_ext_rd_data, .o_status);
  csbm_ext_model ext (.i_clk_sys, .i_rst_n, .i_sel(o_ext_sel), .i_ofs(i_mem_addr[6:0]),
    .o_data(i_ext_rd_data));
  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic acc(input logic w, input logic lin, input logic [11:0] ad, input logic [7:0] d);
    @(negedge i_clk_sys);
    i_mem_rd = !w;
    i_mem_wr = w;
    i_lin_access = lin;
    i_mem_addr = ad;
    i_mem_wr_data = d;
    @(negedge i_clk_sys);
    i_mem_rd = 1'b0;
    i_mem_wr = 1'b0;
  endtask
  task automatic rd(input logic lin, input logic [11:0] ad, input logic [7:0] e);
    acc(1'b0, lin, ad, 8'h00);
    `CHK("rd_data", e, o_mem_rd_data)
  endtask
  task automatic alu(input csbm_op_e op, input logic [7:0] a, b, r, input logic [2:0] fl);
    @(negedge i_clk_sys);
    i_alu_op = op;
    i_alu_a = a;
    i_alu_b = b;
    @(negedge i_clk_sys);
    i_alu_op = CSBM_OP_NONE;
    `CHK("result", r, o_alu_result)
    `CHK("status", {5'b00011, fl}, o_status)
  endtask
  task automatic ev(input logic w, s, t, input logic [1:0] e);
    @(negedge i_clk_sys);
    {i_watchdog_clear_instr, i_sleep_instr, i_watchdog_timeout} = {w, s, t};
    @(negedge i_clk_sys);
    {i_watchdog_clear_instr, i_sleep_instr, i_watchdog_timeout} = 3'b000;
    `CHK("status", {3'b000, e}, o_status[7:3])
  endtask
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    repeat (20) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    `CHK("status", 8'h18, o_status)
    rd(1'b0, 12'h003, 8'h18);
    rd(1'b0, 12'hF83, 8'h18);
    acc(1'b1, 1'b0, 12'h083, 8'hFF);
    `CHK("status", 8'h1F, o_status)
    rd(1'b0, 12'h103, 8'h1F);
    acc(1'b1, 1'b0, 12'h003, 8'h00);
    alu(CSBM_OP_ADD, 8'h0F, 8'h01, 8'h10, 3'b010);
    alu(CSBM_OP_ADD, 8'hF0, 8'h10, 8'h00, 3'b101);
    alu(CSBM_OP_SUB, 8'h05, 8'h05, 8'h00, 3'b111);
    alu(CSBM_OP_SUB, 8'h05, 8'h06, 8'hFF, 3'b000);
    alu(CSBM_OP_LOGIC, 8'h00, 8'h00, 8'h00, 3'b100);
    alu(CSBM_OP_ROT_LEFT, 8'h80, 8'h00, 8'h00, 3'b101);
    alu(CSBM_OP_ROT_RIGHT, 8'h02, 8'h00, 8'h81, 3'b100);
    alu(CSBM_OP_LOGIC, 8'h5A, 8'h00, 8'h5A, 3'b000);
    // The status write and the logic op share one edge, so only the op may touch the flags.
    @(negedge i_clk_sys);
    i_mem_addr = 12'h003;
    i_mem_wr_data = 8'h07;
    i_mem_wr = 1'b1;
    i_alu_op = CSBM_OP_LOGIC;
    i_alu_a = 8'h5A;
    @(negedge i_clk_sys);
    i_mem_wr = 1'b0;
    i_alu_op = CSBM_OP_NONE;
    `CHK("result", 8'h5A, o_alu_result)
    `CHK("status", 8'h18, o_status)
    rd(1'b0, 12'h003, 8'h18);
    acc(1'b1, 1'b0, 12'h003, 8'h05);
    `CHK("status", 8'h1D, o_status)
    ev(1'b0, 1'b0, 1'b1, 2'b01);
    ev(1'b0, 1'b1, 1'b0, 2'b10);
    ev(1'b1, 1'b0, 1'b1, 2'b11);
    ev(1'b0, 1'b1, 1'b1, 2'b10);
    acc(1'b1, 1'b0, 12'h0F5, 8'hA5);
    rd(1'b0, 12'h075, 8'hA5);
    rd(1'b0, 12'hF75, 8'hA5);
    acc(1'b1, 1'b0, 12'h020, 8'h11);
    acc(1'b1, 1'b0, 12'h0EF, 8'h22);
    rd(1'b1, 12'h000, 8'h11);
    rd(1'b1, 12'h09F, 8'h22);
    acc(1'b1, 1'b1, 12'h050, 8'h33);
    rd(1'b0, 12'h0A0, 8'h33);
    acc(1'b1, 1'b0, 12'h120, 8'h44);
    rd(1'b0, 12'h120, 8'h00);
    rd(1'b0, 12'h00C, 8'hCC);
    rd(1'b0, 12'h11F, 8'hDF);
    // A time-out while the enable is low must leave every flag frozen.
    @(negedge i_clk_sys);
    i_ce = 1'b0;
    i_watchdog_timeout = 1'b1;
    @(negedge i_clk_sys);
    i_watchdog_timeout = 1'b0;
    i_ce = 1'b1;
    `CHK("status", 8'h15, o_status)
    @(negedge i_clk_sys);
    i_rst_n = 1'b0;
    @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    `CHK("status", 8'h18, o_status)
    complete_run();
  end
  // A hang counts as a mismatch; the sequence needs well under a thousand cycles.
  initial
  begin
    #100000;
    fails++;
    complete_run();
  end
endmodule
